// File: rtl/compare_channel.sv
// Purpose: One compare channel: equality check and write inhibit.
// Assumes: tick is a one-cycle enable on aclk.
// Notes:   match is combinational and valid only in a tick cycle.
`timescale 1ns/1ps
module compare_channel #(
  parameter int WIDTH = 16
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             tick,
  input  wire logic             late,
  input  wire logic             wr_high,
  input  wire logic             wr_low,
  input  wire logic [WIDTH-1:0] count,
  input  wire logic [WIDTH-1:0] value,
  output logic                  match
);
  logic             inhibit_reg;
  logic [WIDTH-1:0] target;

  if (WIDTH < 2) begin : g_chk
    $error("compare_channel needs WIDTH of at least 2");
  end

  // A high byte write freezes the channel so a half-updated value
  // can never produce a spurious match.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      inhibit_reg <= 1'b0;
    end else if (wr_low) begin
      inhibit_reg <= 1'b0;
    end else if (wr_high) begin
      inhibit_reg <= 1'b1;
    end
  end

  // Slow timer clocks see the event one count later.
  assign target = late ? value + WIDTH'(1) : value;
  assign match  = tick & ~inhibit_reg & (count == target);
endmodule

// File: rtl/timer_cfg.svh
// Purpose: Offsets, field positions, reset values and codes for the
//          compare, single-pulse and PWM timer block.
// Assumes: Registers sit one per 32-bit word on an AXI4-Lite slave.
// Notes:   Function
// Function
// - Match sets flag, drives pin, requests interrupt.
// - Two 16-bit compare registers checked each tick.
// - Compare registers software only, reset 8000h.
// - Output pin latches held low in reset.
// - Compare interrupt needs enable and clear mask.
// - Flag clears: status read, then low byte.
// - High byte write inhibits compare until low.
// - Pin disabled: no level, flag still set.
// - Divide-by-2 matches value, others value plus one.
// - Force copies level to pin, no flag.
// - Force ignored in single-pulse or PWM mode.
// - Single-pulse uses trigger one and compare one.
// - Trigger reloads FFFCh, pulse level, capture FFFDh.
// - Single-pulse match one drives after-pulse level.
// - Single-pulse: no flag one; channel two flag only.
// - Both modes set: only PWM operates.
// - Single-pulse: trigger one no capture, resets counter.
// - PWM: level one on match one, two on two.
// - PWM match two reloads counter with FFFCh.
// - High pulse is register two minus one.
// - PWM keeps both compare flags clear.
// - PWM match two sets capture flag one.
// - All timer events share one interrupt line.
`ifndef TIMER_CFG_SVH
`define TIMER_CFG_SVH
`define TMR_ADDR_W      8
`define TMR_OFF_CMP1_HI 8'h00
`define TMR_OFF_CMP1_LO 8'h04
`define TMR_OFF_CMP2_HI 8'h08
`define TMR_OFF_CMP2_LO 8'h0C
`define TMR_OFF_CTRL1   8'h10
`define TMR_OFF_CTRL2   8'h14
`define TMR_OFF_STATUS  8'h18
`define TMR_OFF_COUNT   8'h1C
`define TMR_OFF_CAP1    8'h20
`define TMR_OFF_CAP2    8'h24
`define TMR_CMP_RESET   16'h8000
`define TMR_CNT_RELOAD  16'hFFFC
`define TMR_CNT_MAX     16'hFFFF
`define TMR_CAP_TRIG    16'hFFFD
`define TMR_CTRL_RESET  8'h00
`define TMR_CC_DIV4     2'h0
`define TMR_CC_DIV2     2'h1
`define TMR_CC_DIV8     2'h2
`define TMR_CC_EXT      2'h3
`define TMR_FLG_CAP1    0
`define TMR_FLG_CMP1    1
`define TMR_FLG_OVF     2
`define TMR_FLG_CAP2    3
`define TMR_FLG_CMP2    4
`define TMR_RESP_OKAY   2'h0
`define TMR_RESP_SLVERR 2'h2
`endif

// File: rtl/timer_compare_pulse_pwm.sv
// Purpose: Output compare, single-pulse and PWM section of a 16-bit
//          free-running timer, with its counter and captures.
// Assumes: AXI4-Lite register access, byte registers in data bits 7:0.
// Notes:   Pins and external clock are synchronised on entry.
`timescale 1ns/1ps
`include "timer_cfg.svh"
module timer_compare_pulse_pwm
  import timer_pkg::*;
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [`TMR_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [`TMR_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  global_irq_mask,
  input  wire logic                  trigger_in_pin_one,
  input  wire logic                  trigger_in_pin_two,
  input  wire logic                  ext_clock_pin,
  output logic                       compare_out_pin_one,
  output logic                       compare_out_pin_two,
  output logic                       compare_pin_oe_one,
  output logic                       compare_pin_oe_two,
  output logic                       timer_irq
);
  localparam logic [15:0] CMP_RESET  = `TMR_CMP_RESET;
  localparam logic [15:0] CNT_RELOAD = `TMR_CNT_RELOAD;

  timer_control_one_t ctrl1_reg;
  timer_control_two_t ctrl2_reg;
  logic [15:0] compare_value_one;
  logic [15:0] compare_value_two;
  logic [15:0] count_reg;
  logic [15:0] capture_value_one;
  logic [15:0] capture_value_two;
  logic [4:0]  flags_reg;
  logic [4:0]  arm_reg;
  logic [4:0]  flag_set;
  logic [4:0]  flag_clr;
  logic [2:0]  presc_reg;
  logic [2:0]  ext_sync_reg;
  logic [2:0]  trig1_sync_reg;
  logic [2:0]  trig2_sync_reg;
  logic [`TMR_ADDR_W-1:0] aw_addr_reg;
  logic [7:0]  w_byte_reg;
  logic        w_lane_reg;
  logic        do_write;
  logic        rd_stb;
  logic        wr_cmp1_hi, wr_cmp1_lo, wr_cmp2_hi, wr_cmp2_lo;
  logic        wr_ctrl1, wr_ctrl2, wr_count;
  logic        rd_status, rd_cmp1_lo, rd_cmp2_lo, rd_count;
  logic        rd_cap1, rd_cap2;
  logic        tick, ext_edge, late;
  logic        edge1, edge2, rise1, fall1, rise2, fall2;
  logic        mode_pwm, mode_pulse, mode_normal;
  logic        match_one, match_two, trig_pulse, overflow;
  logic [31:0] rdata_next;
  logic        rd_hit;

  // Mode decode: PWM overrides single-pulse when both are set.
  assign mode_pwm    = ctrl2_reg.pwm_select;
  assign mode_pulse  = ctrl2_reg.single_pulse_select & ~mode_pwm;
  assign mode_normal = ~mode_pwm & ~mode_pulse;

  // Timer tick: prescaled aclk or a synchronised external edge.
  // The external clock must stay well below a quarter of aclk so that
  // no edge is lost in the synchroniser.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      presc_reg    <= 3'h0;
      ext_sync_reg <= 3'h0;
    end else begin
      presc_reg    <= presc_reg + 3'h1;
      ext_sync_reg <= {ext_sync_reg[1:0], ext_clock_pin};
    end
  end

  assign ext_edge = ctrl2_reg.ext_edge_select
                  ? (ext_sync_reg[1] & ~ext_sync_reg[2])
                  : (~ext_sync_reg[1] & ext_sync_reg[2]);

  always_comb begin
    case (ctrl2_reg.timer_clock_select)
      `TMR_CC_DIV2: tick = presc_reg[0];
      `TMR_CC_DIV4: tick = &presc_reg[1:0];
      `TMR_CC_DIV8: tick = &presc_reg;
      default:      tick = ext_edge;
    endcase
  end

  assign late = ctrl2_reg.timer_clock_select != `TMR_CC_DIV2;

  // Trigger pins pass two flops; the third only feeds edge detection.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trig1_sync_reg <= 3'h0;
      trig2_sync_reg <= 3'h0;
    end else begin
      trig1_sync_reg <= {trig1_sync_reg[1:0], trigger_in_pin_one};
      trig2_sync_reg <= {trig2_sync_reg[1:0], trigger_in_pin_two};
    end
  end

  assign rise1 = trig1_sync_reg[1] & ~trig1_sync_reg[2];
  assign fall1 = ~trig1_sync_reg[1] & trig1_sync_reg[2];
  assign rise2 = trig2_sync_reg[1] & ~trig2_sync_reg[2];
  assign fall2 = ~trig2_sync_reg[1] & trig2_sync_reg[2];
  assign edge1 = ctrl1_reg.trigger_edge_select ? rise1 : fall1;
  assign edge2 = ctrl2_reg.trigger_edge_two ? rise2 : fall2;
  assign trig_pulse = mode_pulse & edge1;

  compare_channel #(.WIDTH(16)) u_cmp_one (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (tick),
    .late    (late),
    .wr_high (wr_cmp1_hi),
    .wr_low  (wr_cmp1_lo),
    .count   (count_reg),
    .value   (compare_value_one),
    .match   (match_one)
  );

  compare_channel #(.WIDTH(16)) u_cmp_two (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (tick),
    .late    (late),
    .wr_high (wr_cmp2_hi),
    .wr_low  (wr_cmp2_lo),
    .count   (count_reg),
    .value   (compare_value_two),
    .match   (match_two)
  );

  // Free-running counter with its three reload causes.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_reg <= CNT_RELOAD;
    end else if (wr_count || trig_pulse) begin
      count_reg <= CNT_RELOAD;
    end else if (mode_pwm && match_two) begin
      count_reg <= CNT_RELOAD;
    end else if (tick) begin
      count_reg <= count_reg + 16'h0001;
    end
  end

  assign overflow = tick & (count_reg == `TMR_CNT_MAX) & ~wr_count
                  & ~trig_pulse & ~(mode_pwm & match_two);

  // Captures; trigger one is detached from capture in both modes.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      capture_value_one <= 16'h0000;
      capture_value_two <= 16'h0000;
    end else begin
      if (trig_pulse) begin
        capture_value_one <= `TMR_CAP_TRIG;
      end else if (mode_normal && edge1) begin
        capture_value_one <= count_reg;
      end
      if (edge2) begin
        capture_value_two <= count_reg;
      end
    end
  end

  // Event sources for each status flag.
  always_comb begin
    flag_set                = 5'h00;
    flag_set[`TMR_FLG_CAP1] = (mode_normal & edge1) | trig_pulse
                            | (mode_pwm & match_two);
    flag_set[`TMR_FLG_CMP1] = mode_normal & match_one;
    flag_set[`TMR_FLG_OVF]  = overflow;
    flag_set[`TMR_FLG_CAP2] = edge2;
    flag_set[`TMR_FLG_CMP2] = ~mode_pwm & match_two;
    flag_clr                = 5'h00;
    flag_clr[`TMR_FLG_CAP1] = rd_cap1;
    flag_clr[`TMR_FLG_CMP1] = rd_cmp1_lo | wr_cmp1_lo;
    flag_clr[`TMR_FLG_OVF]  = rd_count;
    flag_clr[`TMR_FLG_CAP2] = rd_cap2;
    flag_clr[`TMR_FLG_CMP2] = rd_cmp2_lo | wr_cmp2_lo;
  end

  // Two-step clear: a status read arms each set flag, the matching compare low
  // byte access or capture or count read clears it. A new event in that cycle wins.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_reg <= 5'h00;
      arm_reg   <= 5'h00;
    end else begin
      flags_reg <= flag_set | (flags_reg & ~(arm_reg & flag_clr));
      arm_reg   <= (arm_reg & ~flag_clr)
                 | (rd_status ? flags_reg : 5'h00);
    end
  end

  // Channel one pin latch, owned by whichever mode is active.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      compare_out_pin_one <= 1'b0;
    end else if (ctrl2_reg.compare_pin_enable_one) begin
      if (mode_pwm) begin
        if (match_two) begin
          compare_out_pin_one <= ctrl1_reg.pulse_level;
        end else if (match_one) begin
          compare_out_pin_one <= ctrl1_reg.after_pulse_level;
        end
      end else if (mode_pulse) begin
        if (trig_pulse) begin
          compare_out_pin_one <= ctrl1_reg.pulse_level;
        end else if (match_one) begin
          compare_out_pin_one <= ctrl1_reg.after_pulse_level;
        end
      end else if (match_one || ctrl1_reg.force_output_one) begin
        compare_out_pin_one <= ctrl1_reg.after_pulse_level;
      end
    end
  end

  // Channel two drives its pin only in normal mode; in single-pulse mode it
  // only flags elapsed time. Force bits are ignored outside normal mode.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      compare_out_pin_two <= 1'b0;
    end else if (ctrl2_reg.compare_pin_enable_two && mode_normal) begin
      if (match_two || ctrl1_reg.force_output_two) begin
        compare_out_pin_two <= ctrl1_reg.pulse_level;
      end
    end
  end

  // One request line for every timer event, gated by the CPU mask.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_irq <= 1'b0;
    end else begin
      timer_irq <= ~global_irq_mask & (
        (ctrl1_reg.capture_irq_enable
          & (flags_reg[`TMR_FLG_CAP1] | flags_reg[`TMR_FLG_CAP2]))
        | (ctrl1_reg.compare_irq_enable
          & (flags_reg[`TMR_FLG_CMP1] | flags_reg[`TMR_FLG_CMP2]))
        | (ctrl1_reg.overflow_irq_enable & flags_reg[`TMR_FLG_OVF]));
    end
  end

  // Software-owned registers; timer logic never writes them.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      compare_value_one <= CMP_RESET;
      compare_value_two <= CMP_RESET;
      ctrl1_reg         <= `TMR_CTRL_RESET;
      ctrl2_reg         <= `TMR_CTRL_RESET;
    end else begin
      if (wr_cmp1_hi) compare_value_one[15:8] <= w_byte_reg;
      if (wr_cmp1_lo) compare_value_one[7:0]  <= w_byte_reg;
      if (wr_cmp2_hi) compare_value_two[15:8] <= w_byte_reg;
      if (wr_cmp2_lo) compare_value_two[7:0]  <= w_byte_reg;
      if (wr_ctrl1)   ctrl1_reg <= timer_control_one_t'(w_byte_reg);
      if (wr_ctrl2)   ctrl2_reg <= timer_control_two_t'(w_byte_reg);
    end
  end

  assign compare_pin_oe_one = ctrl2_reg.compare_pin_enable_one;
  assign compare_pin_oe_two = ctrl2_reg.compare_pin_enable_two;

  // Write channel: address and data are taken in either order; the
  // write happens once both are held and no response is pending.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `TMR_RESP_OKAY;
      aw_addr_reg   <= '0;
      w_byte_reg    <= 8'h00;
      w_lane_reg    <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_reg   <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_byte_reg   <= s_axi_wdata[7:0];
        w_lane_reg   <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_reg <= `TMR_OFF_COUNT
                        && aw_addr_reg[1:0] == 2'h0)
                      ? `TMR_RESP_OKAY : `TMR_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  assign do_write = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;

  // Write decode; the counter write counts even with lane 0 off.
  assign wr_cmp1_hi = do_write & w_lane_reg
                    & (aw_addr_reg == `TMR_OFF_CMP1_HI);
  assign wr_cmp1_lo = do_write & w_lane_reg
                    & (aw_addr_reg == `TMR_OFF_CMP1_LO);
  assign wr_cmp2_hi = do_write & w_lane_reg
                    & (aw_addr_reg == `TMR_OFF_CMP2_HI);
  assign wr_cmp2_lo = do_write & w_lane_reg
                    & (aw_addr_reg == `TMR_OFF_CMP2_LO);
  assign wr_ctrl1   = do_write & w_lane_reg
                    & (aw_addr_reg == `TMR_OFF_CTRL1);
  assign wr_ctrl2   = do_write & w_lane_reg
                    & (aw_addr_reg == `TMR_OFF_CTRL2);
  assign wr_count   = do_write & (aw_addr_reg == `TMR_OFF_COUNT);

  // Read decode; reads have side effects on the flag clear sequence.
  assign rd_stb     = s_axi_arvalid & s_axi_arready;
  assign rd_status  = rd_stb & (s_axi_araddr == `TMR_OFF_STATUS);
  assign rd_cmp1_lo = rd_stb & (s_axi_araddr == `TMR_OFF_CMP1_LO);
  assign rd_cmp2_lo = rd_stb & (s_axi_araddr == `TMR_OFF_CMP2_LO);
  assign rd_count   = rd_stb & (s_axi_araddr == `TMR_OFF_COUNT);
  assign rd_cap1    = rd_stb & (s_axi_araddr == `TMR_OFF_CAP1);
  assign rd_cap2    = rd_stb & (s_axi_araddr == `TMR_OFF_CAP2);

  always_comb begin
    rd_hit     = 1'b1;
    rdata_next = 32'h0000_0000;
    case (s_axi_araddr)
      `TMR_OFF_CMP1_HI: rdata_next[7:0] = compare_value_one[15:8];
      `TMR_OFF_CMP1_LO: rdata_next[7:0] = compare_value_one[7:0];
      `TMR_OFF_CMP2_HI: rdata_next[7:0] = compare_value_two[15:8];
      `TMR_OFF_CMP2_LO: rdata_next[7:0] = compare_value_two[7:0];
      `TMR_OFF_CTRL1:   rdata_next[7:0] = ctrl1_reg;
      `TMR_OFF_CTRL2:   rdata_next[7:0] = ctrl2_reg;
      `TMR_OFF_STATUS:  rdata_next[7:0] = {flags_reg, 3'h0};
      `TMR_OFF_COUNT:   rdata_next[15:0] = count_reg;
      `TMR_OFF_CAP1:    rdata_next[15:0] = capture_value_one;
      `TMR_OFF_CAP2:    rdata_next[15:0] = capture_value_two;
      default:          rd_hit = 1'b0;
    endcase
  end

  // Read channel: one read in flight, data held until rready.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `TMR_RESP_OKAY;
    end else if (rd_stb) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rdata_next;
      s_axi_rresp   <= rd_hit ? `TMR_RESP_OKAY : `TMR_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule

// File: rtl/timer_pkg.sv
// Purpose: Types shared by the timer block.
// Assumes: Field order matches the control byte layouts.
// Notes:   Bit 7 is the first member of each struct.
package timer_pkg;
  typedef struct packed {
    logic capture_irq_enable;
    logic compare_irq_enable;
    logic overflow_irq_enable;
    logic force_output_two;
    logic force_output_one;
    logic pulse_level;
    logic trigger_edge_select;
    logic after_pulse_level;
  } timer_control_one_t;
  typedef struct packed {
    logic       compare_pin_enable_one;
    logic       compare_pin_enable_two;
    logic       single_pulse_select;
    logic       pwm_select;
    logic [1:0] timer_clock_select;
    logic       trigger_edge_two;
    logic       ext_edge_select;
  } timer_control_two_t;
endpackage

// File: tb/pin_stimulus.sv
// Purpose: Far side of the timer: trigger inputs and external clock.
// Assumes: The bench asks for a trigger level through fire.
// Notes:   External clock and second trigger stand still.
`timescale 1ns/1ps
module pin_stimulus (
  input  wire logic aclk,
  input  wire logic fire,
  output logic      trig_one,
  output logic      trig_two,
  output logic      ext_clk
);
  // The trigger pin follows the request one cycle later, like a real pad.
  always_ff @(posedge aclk) begin
    trig_one <= fire;
  end
  // Unused inputs are held quiet so they cannot fake an edge.
  assign trig_two = 1'b0;
  assign ext_clk  = 1'b0;
endmodule

// File: tb/timer_compare_pulse_pwm_checker.sv
// Purpose: Port-level assertions for the compare, pulse and PWM timer.
// Assumes: One clock, synchronous active-low reset, one-cycle read answer, two-cycle write answer.
// Notes:   Pin relations lean on the registered pin enables.
`timescale 1ns/1ps
module timer_compare_pulse_pwm_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        global_irq_mask,
  input wire logic        compare_out_pin_one,
  input wire logic        compare_out_pin_two,
  input wire logic        compare_pin_oe_one,
  input wire logic        compare_pin_oe_two,
  input wire logic        timer_irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // The first edge after release still shows what reset left behind.
  a_reset_pins_low: assert property ($rose(aresetn) |->
    !compare_out_pin_one && !compare_out_pin_two) else $error("pin not low");
  a_reset_quiet: assert property ($rose(aresetn) |-> !timer_irq &&
    !compare_pin_oe_one && !compare_pin_oe_two) else $error("reset not quiet");
  // The request is registered, so the mask of one cycle ago governs it.
  a_irq_masked: assert property ($past(global_irq_mask) |->
    !timer_irq) else $error("interrupt while masked");
  // A disabled pin is plain I/O: its latch must not move.
  a_pin1_needs_oe: assert property ($changed(compare_out_pin_one) |->
    compare_pin_oe_one || $past(compare_pin_oe_one)) else $error("pin1 moved");
  a_pin2_needs_oe: assert property ($changed(compare_out_pin_two) |->
    compare_pin_oe_two || $past(compare_pin_oe_two)) else $error("pin2 moved");
  // Bus answers arrive after the fixed latency the slave promises.
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid) else $error("no bvalid");
  a_write_block: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("write ready too early");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("no rvalid");
  a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read ready too early");

  c_pin_rise: cover property ($rose(compare_out_pin_one));
  c_irq_rise: cover property ($rose(timer_irq));
  c_pin_two: cover property ($rose(compare_out_pin_two));
endmodule

bind timer_compare_pulse_pwm timer_compare_pulse_pwm_checker u_chk (.*);

// File: tb/timer_compare_pulse_pwm_tb.sv
// Purpose: Self-checking bench for the compare, pulse and PWM timer.
// Assumes: Divide-by-2 timer clock, so one count lasts two aclk cycles.
// Notes:   Pulse widths are measured on the pin in aclk cycles.
`timescale 1ns/1ps
`include "timer_cfg.svh"
module timer_compare_pulse_pwm_tb;
  typedef struct packed {
    logic       we;
    logic [7:0] a;
    logic [7:0] w;
    logic [7:0] e;
    logic [1:0] r;
  } row_t;
  logic        aclk, aresetn, global_irq_mask, fire;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic        trigger_in_pin_one, trigger_in_pin_two, ext_clock_pin;
  logic        compare_out_pin_one, compare_out_pin_two, timer_irq;
  logic        compare_pin_oe_one, compare_pin_oe_two;
  logic [31:0] d;
  logic [1:0]  r;
  int          n, hi, lo, miscompares, n_tests;
  // Reset values first, then write and read back, then an unmapped place.
  row_t rows [9] = '{'{0, 8'h00, 8'h00, 8'h80, 2'h0},
    '{0, 8'h04, 8'h00, 8'h00, 2'h0}, '{0, 8'h08, 8'h00, 8'h80, 2'h0},
    '{0, 8'h0C, 8'h00, 8'h00, 2'h0}, '{0, 8'h10, 8'h00, 8'h00, 2'h0},
    '{0, 8'h14, 8'h00, 8'h00, 2'h0}, '{1, 8'h08, 8'h12, 8'h12, 2'h0},
    '{1, 8'h0C, 8'h34, 8'h34, 2'h0},
    '{0, 8'h40, 8'h00, 8'h00, `TMR_RESP_SLVERR}};

  timer_compare_pulse_pwm u_dut (.*);
  pin_stimulus u_pins (.aclk, .fire, .trig_one(trigger_in_pin_one),
    .trig_two(trigger_in_pin_two), .ext_clk(ext_clock_pin));

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Address and data go out together; each drops once taken.
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h000000, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", 16'h0000, {14'h0000, s_axi_bresp});
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v,
                    output logic [1:0] rr);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    v = s_axi_rdata;
    rr = s_axi_rresp;
  endtask
  // Bounded wait for pin one to reach a level; k counts the edges taken.
  task automatic wait_pin(input logic v, input int lim, output int k);
    k = 0;
    while (compare_out_pin_one !== v && k < lim) begin
      @(posedge aclk);
      k++;
    end
  endtask
  task automatic end_of_test;
    $display("TB: %0d checks, %0d mismatches", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  // A hung bus handshake ends the run here; pin waits stop at their own limit.
  initial begin
    repeat (6000) @(posedge aclk);
    miscompares++;
    end_of_test();
  end
  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, fire} = '0;
    s_axi_wstrb = 4'hF;
    aresetn = 1'b0;
    global_irq_mask = 1'b1;
    miscompares = 0;
    n_tests = 0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("pins", 16'h0000, {14'h0, compare_out_pin_one, compare_out_pin_two});
    foreach (rows[i]) begin
      if (rows[i].we) wr(rows[i].a, rows[i].w);
      rd(rows[i].a, d, r);
      chk("rdata", {8'h00, rows[i].e}, d[15:0]);
      chk("rresp", {14'h0, rows[i].r}, {14'h0, r});
    end
    // Plain match: pin enabled, compare interrupt on, mask held at first.
    wr(8'h14, 8'h84);
    wr(8'h10, 8'h41);
    wr(8'h00, 8'h00);
    rd(8'h18, d, r);
    wr(8'h04, 8'h10);
    wr(8'h1C, 8'h00);
    wait_pin(1'b1, 200, n);
    chk("pin_one", 16'h0001, 16'(compare_out_pin_one));
    chk("irq_masked", 16'h0000, 16'(timer_irq));
    global_irq_mask <= 1'b0;
    repeat (3) @(posedge aclk);
    chk("irq", 16'h0001, 16'(timer_irq));
    rd(8'h18, d, r);
    chk("flag_set", 16'h0010, {8'h00, d[7:0] & 8'h10});
    wr(8'h04, 8'h10);
    rd(8'h18, d, r);
    chk("flag_clr", 16'h0000, {8'h00, d[7:0] & 8'h10});
    chk("irq_clr", 16'h0000, 16'(timer_irq));
    // Forcing moves both pins at once and leaves the flags alone.
    wr(8'h14, 8'hC4);
    wr(8'h10, 8'h1C);
    repeat (2) @(posedge aclk);
    chk("forced", 16'h0001, {14'h0, compare_out_pin_one, compare_out_pin_two});
    rd(8'h18, d, r);
    chk("force_flag", 16'h0000, {8'h00, d[7:0] & 8'h90});
    // High byte alone inhibits the channel; the low byte revives it.
    wr(8'h10, 8'h01);
    wr(8'h00, 8'h00);
    wr(8'h1C, 8'h00);
    wait_pin(1'b1, 100, n);
    chk("inhibit", 16'h0000, 16'(compare_out_pin_one));
    wr(8'h04, 8'h08);
    wr(8'h1C, 8'h00);
    wait_pin(1'b1, 200, n);
    chk("revive", 16'h0001, 16'(compare_out_pin_one));
    // PWM with both mode bits and a force bit that must be ignored.
    wr(8'h08, 8'h00);
    rd(8'h18, d, r);
    wr(8'h04, 8'h08);
    wr(8'h10, 8'h09);
    wr(8'h14, 8'hB4);
    wr(8'h0C, 8'h10);
    wr(8'h1C, 8'h00);
    wait_pin(1'b0, 100, n);
    wait_pin(1'b1, 100, n);
    wait_pin(1'b0, 100, hi);
    wait_pin(1'b1, 100, lo);
    chk("pwm_high", 16'd16, 16'(hi));
    chk("pwm_low", 16'd26, 16'(lo));
    rd(8'h18, d, r);
    chk("pwm_flags", 16'h0008, {8'h00, d[7:0] & 8'h98});
    rd(8'h20, d, r);
    // Single pulse: pin forced low in normal mode, then a rising trigger.
    wr(8'h14, 8'h84);
    wr(8'h10, 8'h08);
    wr(8'h14, 8'hA4);
    wr(8'h10, 8'h06);
    fire <= 1'b1;
    wait_pin(1'b1, 20, n);
    chk("pulse_on", 16'h0001, 16'(compare_out_pin_one));
    wait_pin(1'b0, 100, n);
    chk("pulse_len", 16'h0001, 16'(n >= 24 && n <= 27));
    rd(8'h18, d, r);
    chk("pulse_flags", 16'h0008, {8'h00, d[7:0] & 8'h18});
    rd(8'h20, d, r);
    chk("capture", `TMR_CAP_TRIG, d[15:0]);
    end_of_test();
  end
endmodule
